// [design/fpcs_pkg.sv]
package fpcs_pkg;

    // register offsets, byte addresses on the 32-bit register port
    localparam logic [7:0]  FPCS_CTRL_A_OFS     = 8'h44;
    localparam logic [7:0]  FPCS_RATIO_OFS      = 8'h48;
    localparam logic [7:0]  FPCS_CTRL_B_OFS     = 8'h4c;
    localparam logic [7:0]  FPCS_STATE_OFS      = 8'h50;
    localparam logic [7:0]  FPCS_IRQ_STAT_OFS   = 8'h54;
    localparam logic [7:0]  FPCS_IRQ_MASK_OFS   = 8'h58;

    // field positions
    localparam int          FPCS_ENABLE_BIT     = 1;
    localparam int          FPCS_ON_REQ_BIT     = 7;
    localparam int          FPCS_FRAC_LSB       = 16;
    localparam int          FPCS_INT_LSB        = 0;
    localparam int          FPCS_DIV_LSB        = 16;
    localparam int          FPCS_BYPASS_BIT     = 12;
    localparam int          FPCS_LOCK_TIMEOUT_SELECT_LSB      = 8;
    localparam int          FPCS_REFSEL_LSB     = 4;
    localparam int          FPCS_WUF_BIT        = 3;
    localparam int          FPCS_LOW_POWER_LOOP_BIT       = 2;
    localparam int          FPCS_FILT_LSB       = 0;

    // values after reset
    localparam logic [7:0]  FPCS_CTRL_A_RST     = 8'h80;
    localparam logic [31:0] FPCS_RATIO_RST      = 32'h0000_0000;
    localparam logic [31:0] FPCS_CTRL_B_RST     = 32'h0000_0000;
    localparam logic [16:0] FPCS_MULT_RST       = 17'h00010;
    localparam logic [12:0] FPCS_RDIV_RST       = 13'h0002;

    // timing: clock period, time-out unit, start-up time, enable settle
    localparam int          FPCS_CLK_PERIOD_PS  = 5000;
    localparam int          FPCS_TO_UNIT_MS     = 1;
    localparam int          FPCS_MS_CYC         =
        FPCS_TO_UNIT_MS * 1000000000 / FPCS_CLK_PERIOD_PS;
    localparam int          FPCS_STARTUP_NS     = 500;
    localparam logic [7:0]  FPCS_STARTUP_CYC    =
        8'((FPCS_STARTUP_NS * 1000 + FPCS_CLK_PERIOD_PS - 1)
           / FPCS_CLK_PERIOD_PS);
    localparam logic [2:0]  FPCS_SETTLE_CYC     = 3'h4;
    localparam logic [1:0]  FPCS_TO_BASE        = 2'h2;

    typedef enum logic [1:0] {
        FPCS_REF_XTAL32 = 2'h0,
        FPCS_REF_XTAL   = 2'h1,
        FPCS_REF_GCLK   = 2'h2
    } fpcs_ref_e;

    typedef struct packed {
        logic [3:0]  frac;
        logic [11:0] mint;
    } fpcs_ratio_s;

    typedef struct packed {
        logic [10:0] div;
        logic        bypass;
        logic [2:0]  lock_timeout_select;
        logic [1:0]  refsel;
        logic        fast_wakeup;
        logic        low_power_loop;
        logic [1:0]  filt;
    } fpcs_ctrl_s;

    typedef struct packed {
        logic        on_req;
        logic        enable;
        fpcs_ratio_s ratio;
        fpcs_ctrl_s  ctrl;
        logic [2:0]  lk_s;
        logic [2:0]  rq_s;
        logic        lock;
        logic        req;
        logic        en_stat;
        logic [2:0]  settle_cnt;
        logic [7:0]  start_cnt;
        logic        start_done;
        logic        lock_seen;
        logic        clk_on;
        logic        div_on;
        logic [17:0] ms_cnt;
        logic [3:0]  ms_el;
        logic        to_done;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic        irq;
        logic [16:0] mult_x16;
        logic [12:0] ref_div;
        logic [31:0] rdata;
    } fpcs_state_s;

endpackage : fpcs_pkg

// [design/fpcs_top.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module fpcs_top
    import fpcs_pkg::*;
#(
    parameter logic [17:0] MS_CYC = 18'(FPCS_MS_CYC)
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // loop core
    input  wire logic        pll_lock_i,
    input  wire logic        clk_request_i,
    output logic             pll_run_o,
    output logic             output_clock_running_o,
    output logic             prescaler_en_o,
    output logic      [12:0] ref_div_o,
    output logic      [16:0] mult_x16_o,
    output logic      [3:0]  multiplier_fraction_o,
    output logic      [11:0] multiplier_integer_o,
    output logic      [1:0]  reference_select_o,
    output logic             low_power_loop_o,
    output logic      [1:0]  loop_filter_o,
    // interrupt
    output logic             irq_o
);

    fpcs_state_s r;
    fpcs_state_s n;
    logic        active_req;
    logic [3:0]  ev;
    logic [3:0]  to_target;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n          = r;
        n.rdata    = 32'h0000_0000;
        active_req = 1'b0;
        ev         = 4'h0;
        to_target  = {FPCS_TO_BASE, r.ctrl.lock_timeout_select[1:0]};

        // pins pass three flops; a change counts when the last two agree
        n.lk_s = {r.lk_s[1:0], pll_lock_i};
        n.rq_s = {r.rq_s[1:0], clk_request_i};
        if (r.lk_s[1] == r.lk_s[2]) begin
            n.lock = r.lk_s[2];
        end
        if (r.rq_s[1] == r.rq_s[2]) begin
            n.req = r.rq_s[2];
        end

        // register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                FPCS_CTRL_A_OFS: begin
                    n.enable = reg_wdata_i[FPCS_ENABLE_BIT];
                    n.on_req = reg_wdata_i[FPCS_ON_REQ_BIT];
                end
                FPCS_RATIO_OFS: begin
                    n.ratio.frac = reg_wdata_i[FPCS_FRAC_LSB +: 4];
                    n.ratio.mint = reg_wdata_i[FPCS_INT_LSB +: 12];
                end
                FPCS_CTRL_B_OFS: begin
                    n.ctrl.div    = reg_wdata_i[FPCS_DIV_LSB +: 11];
                    n.ctrl.bypass = reg_wdata_i[FPCS_BYPASS_BIT];
                    n.ctrl.lock_timeout_select  = reg_wdata_i[FPCS_LOCK_TIMEOUT_SELECT_LSB +: 3];
                    n.ctrl.refsel = reg_wdata_i[FPCS_REFSEL_LSB +: 2];
                    n.ctrl.fast_wakeup    = reg_wdata_i[FPCS_WUF_BIT];
                    n.ctrl.low_power_loop   = reg_wdata_i[FPCS_LOW_POWER_LOOP_BIT];
                    n.ctrl.filt   = reg_wdata_i[FPCS_FILT_LSB +: 2];
                end
                FPCS_IRQ_MASK_OFS: begin
                    n.irq_mask = reg_wdata_i[3:0];
                end
                default: begin
                end
            endcase
        end

        // on-demand gating of the run request
        active_req = r.enable && (!r.on_req || r.req);

        // real state follows the request after a settle delay
        if (active_req != r.en_stat) begin
            if (r.settle_cnt == FPCS_SETTLE_CYC - 3'h1) begin
                n.en_stat    = active_req;
                n.settle_cnt = 3'h0;
            end else begin
                n.settle_cnt = r.settle_cnt + 3'h1;
            end
        end else begin
            n.settle_cnt = 3'h0;
        end

        // start-up timer restarts on every enable
        if (!r.en_stat) begin
            n.start_cnt  = 8'h00;
            n.start_done = 1'b0;
            n.lock_seen  = 1'b0;
        end else begin
            if (!r.start_done) begin
                n.start_cnt = r.start_cnt + 8'h01;
                if (r.start_cnt == FPCS_STARTUP_CYC - 8'h01) begin
                    n.start_done = 1'b1;
                end
            end
            if (r.lock) begin
                n.lock_seen = 1'b1;
            end
        end

        // fast wake-up lets the clock out before the first lock
        // once lock was seen its loss gates the clock again
        // lock low gates the clock unless bypassed or fast wake-up has not yet seen lock
        n.clk_on = r.en_stat && r.start_done
                   && (r.ctrl.bypass || r.lock
                       || (r.ctrl.fast_wakeup && !r.lock_seen));

        // prescaler runs only for the main crystal reference
        n.div_on = r.en_stat && (r.ctrl.refsel == FPCS_REF_XTAL);

        // lock time-out; reserved codes behave as no time-out
        if (!r.en_stat || r.lock || !r.ctrl.lock_timeout_select[2]) begin
            n.ms_cnt  = 18'h00000;
            n.ms_el   = 4'h0;
            n.to_done = 1'b0;
        end else if (!r.to_done) begin
            if (r.ms_cnt == MS_CYC - 18'h00001) begin
                n.ms_cnt = 18'h00000;
                n.ms_el  = r.ms_el + 4'h1;
                if (r.ms_el + 4'h1 == to_target) begin
                    n.to_done = 1'b1;
                end
            end else begin
                n.ms_cnt = r.ms_cnt + 18'h00001;
            end
        end

        // multiplier in sixteenths: (int + 1) * 16 + frac
        n.mult_x16 = {13'({1'b0, r.ratio.mint} + 13'h0001), r.ratio.frac};
        // crystal divide ratio 2 * (div + 1)
        n.ref_div  = {12'({1'b0, r.ctrl.div} + 12'h001), 1'b0};

        // events: lock gained, lock lost, clock ready, time-out
        ev[0] = n.lock && !r.lock;
        ev[1] = !n.lock && r.lock;
        ev[2] = n.clk_on && !r.clk_on;
        ev[3] = n.to_done && !r.to_done;
        // a new event beats a write-one clear in the same cycle
        n.irq_stat = r.irq_stat | ev;
        if (reg_wr_i && reg_addr_i == FPCS_IRQ_STAT_OFS) begin
            n.irq_stat = (r.irq_stat & ~reg_wdata_i[3:0]) | ev;
        end
        n.irq = |(n.irq_stat & n.irq_mask);

        // register reads, data one cycle later; unmapped reads give zero
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                FPCS_CTRL_A_OFS: begin
                    n.rdata[FPCS_ON_REQ_BIT] = r.on_req;
                    n.rdata[FPCS_ENABLE_BIT] = r.enable;
                end
                FPCS_RATIO_OFS: begin
                    n.rdata[FPCS_FRAC_LSB +: 4] = r.ratio.frac;
                    n.rdata[FPCS_INT_LSB +: 12] = r.ratio.mint;
                end
                FPCS_CTRL_B_OFS: begin
                    n.rdata[FPCS_DIV_LSB +: 11]   = r.ctrl.div;
                    n.rdata[FPCS_BYPASS_BIT]      = r.ctrl.bypass;
                    n.rdata[FPCS_LOCK_TIMEOUT_SELECT_LSB +: 3]  = r.ctrl.lock_timeout_select;
                    n.rdata[FPCS_REFSEL_LSB +: 2] = r.ctrl.refsel;
                    n.rdata[FPCS_WUF_BIT]         = r.ctrl.fast_wakeup;
                    n.rdata[FPCS_LOW_POWER_LOOP_BIT]        = r.ctrl.low_power_loop;
                    n.rdata[FPCS_FILT_LSB +: 2]   = r.ctrl.filt;
                end
                FPCS_STATE_OFS: begin
                    n.rdata[3:0] = {r.div_on, r.en_stat, r.clk_on, r.lock};
                end
                FPCS_IRQ_STAT_OFS: begin
                    n.rdata[3:0] = r.irq_stat;
                end
                FPCS_IRQ_MASK_OFS: begin
                    n.rdata[3:0] = r.irq_mask;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r        <= '0;
            r.on_req <= FPCS_CTRL_A_RST[FPCS_ON_REQ_BIT];
            r.enable <= FPCS_CTRL_A_RST[FPCS_ENABLE_BIT];
            r.ratio  <= fpcs_ratio_s'({FPCS_RATIO_RST[19:16],
                                       FPCS_RATIO_RST[11:0]});
            r.ctrl   <= fpcs_ctrl_s'({FPCS_CTRL_B_RST[26:16],
                                      FPCS_CTRL_B_RST[12],
                                      FPCS_CTRL_B_RST[10:8],
                                      FPCS_CTRL_B_RST[5:0]});
            r.mult_x16 <= FPCS_MULT_RST;
            r.ref_div  <= FPCS_RDIV_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata_o            = r.rdata;
    assign pll_run_o              = r.en_stat;
    assign output_clock_running_o = r.clk_on;
    assign prescaler_en_o         = r.div_on;
    assign ref_div_o              = r.ref_div;
    assign mult_x16_o             = r.mult_x16;
    assign multiplier_fraction_o  = r.ratio.frac;
    assign multiplier_integer_o   = r.ratio.mint;
    assign reference_select_o     = r.ctrl.refsel;
    assign low_power_loop_o       = r.ctrl.low_power_loop;
    assign loop_filter_o          = r.ctrl.filt;
    assign irq_o                  = r.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_ratio_wr;
        reg_wr_i && reg_addr_i == FPCS_RATIO_OFS |=>
            r.ratio.frac == $past(reg_wdata_i[19:16])
            && r.ratio.mint == $past(reg_wdata_i[11:0]);
    endproperty
    a_ratio_wr: assert property (p_ratio_wr)
        else $error("ratio write not stored");

    property p_lock_gate;
        !r.ctrl.bypass && !r.ctrl.fast_wakeup && !r.lock |=> !r.clk_on;
    endproperty
    a_lock_gate: assert property (p_lock_gate)
        else $error("clock on without lock");

    property p_bypass_run;
        r.ctrl.bypass && r.en_stat && r.start_done ##1 r.en_stat
            |-> r.clk_on;
    endproperty
    a_bypass_run: assert property (p_bypass_run)
        else $error("bypass clock not running");

    property p_timeout_code;
        $rose(r.to_done) |-> $past(r.ctrl.lock_timeout_select[2]) && !$past(r.lock)
            && r.ms_el == {FPCS_TO_BASE, $past(r.ctrl.lock_timeout_select[1:0])};
    endproperty
    a_timeout_code: assert property (p_timeout_code)
        else $error("time-out at wrong count");

    property p_startup_gate;
        $rose(r.clk_on) |-> $past(r.start_done) && $past(r.en_stat);
    endproperty
    a_startup_gate: assert property (p_startup_gate)
        else $error("clock released before start-up");

    property p_state_read;
        reg_rd_i && reg_addr_i == FPCS_STATE_OFS |=>
            reg_rdata_o == {28'h0000000, $past(r.div_on),
                            $past(r.en_stat), $past(r.clk_on),
                            $past(r.lock)};
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("status read mismatch");

    property p_enable_settle;
        r.enable && !r.on_req && !r.en_stat |-> ##[1:5] r.en_stat;
    endproperty
    a_enable_settle: assert property (p_enable_settle)
        else $error("enable status did not follow");

    property p_on_demand;
        r.on_req && !r.req && !r.en_stat |=> !r.en_stat;
    endproperty
    a_on_demand: assert property (p_on_demand)
        else $error("ran without request");

    property p_div_wr;
        reg_wr_i && reg_addr_i == FPCS_CTRL_B_OFS |=>
            r.ctrl.div == $past(reg_wdata_i[FPCS_DIV_LSB +: 11]);
    endproperty
    a_div_wr: assert property (p_div_wr)
        else $error("prescale field not stored");

    property p_refsel_out;
        reg_wr_i && reg_addr_i == FPCS_CTRL_B_OFS |=>
            reference_select_o == $past(reg_wdata_i[FPCS_REFSEL_LSB +: 2]);
    endproperty
    a_refsel_out: assert property (p_refsel_out)
        else $error("reference select not applied");

    property p_low_power_loop_out;
        reg_wr_i && reg_addr_i == FPCS_CTRL_B_OFS |=>
            low_power_loop_o == $past(reg_wdata_i[FPCS_LOW_POWER_LOOP_BIT]);
    endproperty
    a_low_power_loop_out: assert property (p_low_power_loop_out)
        else $error("low-power select not applied");

    property p_filt_out;
        reg_wr_i && reg_addr_i == FPCS_CTRL_B_OFS |=>
            loop_filter_o == $past(reg_wdata_i[FPCS_FILT_LSB +: 2]);
    endproperty
    a_filt_out: assert property (p_filt_out)
        else $error("loop filter not applied");

    property p_presc_stat;
        prescaler_en_o == ($past(r.en_stat)
                           && ($past(r.ctrl.refsel) == FPCS_REF_XTAL));
    endproperty
    a_presc_stat: assert property (p_presc_stat)
        else $error("prescaler status wrong");

    property p_lock_stat;
        r.lk_s[1] == r.lk_s[2] |=> r.lock == $past(r.lk_s[2]);
    endproperty
    a_lock_stat: assert property (p_lock_stat)
        else $error("lock status not following pin");

    property p_mult_out;
        mult_x16_o == ({5'h00, $past(r.ratio.mint)} + 17'h00001)
                      * 17'h00010 + {13'h0000, $past(r.ratio.frac)};
    endproperty
    a_mult_out: assert property (p_mult_out)
        else $error("multiplier output wrong");

    property p_rdiv_out;
        ref_div_o == ({2'h0, $past(r.ctrl.div)} + 13'h0001) * 13'h0002;
    endproperty
    a_rdiv_out: assert property (p_rdiv_out)
        else $error("reference divide ratio wrong");

    property p_irq_level;
        irq_o == |(r.irq_stat & r.irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt without cause");

endmodule : fpcs_top

`default_nettype wire

// [tb/fpcs_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module fpcs_core_model #(
    parameter int LOCK_DLY = 12
) (
    // clock and command
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic lock_en_i,
    // loop core pin
    output logic      lock_o
);
    int cnt;

    initial begin
        cnt    = 0;
        lock_o = 1'b0;
    end

    // lock only on a running loop; it falls at once when the loop stops
    always @(posedge clk_i) begin
        if (!run_i || !lock_en_i) begin
            cnt    <= 0;
            lock_o <= 1'b0;
        end else begin
            if (cnt < LOCK_DLY) begin
                cnt <= cnt + 1;
            end
            lock_o <= (cnt >= LOCK_DLY);
        end
    end
endmodule : fpcs_core_model

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end end

module tb;
    import fpcs_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        pll_lock_i;
    logic        clk_request_i = 1'b0;
    logic        pll_run_o;
    logic        output_clock_running_o;
    logic        prescaler_en_o;
    logic [12:0] ref_div_o;
    logic [16:0] mult_x16_o;
    logic [3:0]  multiplier_fraction_o;
    logic [11:0] multiplier_integer_o;
    logic [1:0]  reference_select_o;
    logic        low_power_loop_o;
    logic [1:0]  loop_filter_o;
    logic        irq_o;
    logic        lock_en = 1'b0;
    logic [31:0] rd_q;
    int          fail_count = 0;
    int          compares = 0;
    int          m_ratio = 0;
    int          m_ctrlb = 0;
    int          r;
    int          c;

    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // short millisecond so lock time-outs fit the run
    fpcs_top #(.MS_CYC(18'd20)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .pll_lock_i(pll_lock_i), .clk_request_i(clk_request_i),
        .pll_run_o(pll_run_o),
        .output_clock_running_o(output_clock_running_o),
        .prescaler_en_o(prescaler_en_o), .ref_div_o(ref_div_o),
        .mult_x16_o(mult_x16_o),
        .multiplier_fraction_o(multiplier_fraction_o),
        .multiplier_integer_o(multiplier_integer_o),
        .reference_select_o(reference_select_o),
        .low_power_loop_o(low_power_loop_o), .loop_filter_o(loop_filter_o),
        .irq_o(irq_o));

    fpcs_core_model core (.clk_i(clk_sys_i), .run_i(pll_run_o),
        .lock_en_i(lock_en), .lock_o(pll_lock_i));

    task automatic summarize;
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        // register model: only documented fields are kept
        if (a == FPCS_RATIO_OFS) m_ratio = d & 32'h000f0fff;
        if (a == FPCS_CTRL_B_OFS) m_ctrlb = d & 32'h07ff173f;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
        #1 rd_q = reg_rdata_o;
    endtask : rd

    // poll a status bit (lock, clock on or enable), the change is not immediate
    task automatic poll(input int b, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            rd(FPCS_STATE_OFS);
            if (rd_q[b] === v) break;
        end
    endtask : poll

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    initial begin
        #(5ns * 20000);
        fail_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'hca110444));
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        cyc(1);
        `CHK("mult_rst", 17'h10, mult_x16_o)
        `CHK("div_rst", 13'h2, ref_div_o)
        rd(FPCS_CTRL_A_OFS); `CHK("ctrla_rst", 32'h80, rd_q)
        rd(FPCS_RATIO_OFS); `CHK("ratio_rst", 32'h0, rd_q)
        rd(FPCS_CTRL_B_OFS); `CHK("ctrlb_rst", 32'h0, rd_q)
        wr(FPCS_STATE_OFS, 32'hff);
        rd(FPCS_STATE_OFS); `CHK("state_ro", 32'h0, rd_q)
        wr(8'h60, 32'hffff_ffff);
        rd(8'h60); `CHK("unmapped", 32'h0, rd_q)
        // random fields, every reference and filter code visited
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            c = ($urandom & 32'hffff_ffc0) | ((i % 3) << 4) | (i % 4);
            wr(FPCS_RATIO_OFS, r);
            wr(FPCS_CTRL_B_OFS, c);
            rd(FPCS_RATIO_OFS); `CHK("ratio", m_ratio, rd_q)
            rd(FPCS_CTRL_B_OFS); `CHK("ctrlb", m_ctrlb, rd_q)
            `CHK("frac", 4'((r >> 16) & 15), multiplier_fraction_o)
            `CHK("int", 12'(r & 32'hfff), multiplier_integer_o)
            `CHK("mult", 17'(((r & 32'hfff) + 1) * 16 + ((r >> 16) & 15)),
                mult_x16_o)
            `CHK("rdiv", 13'(2 * (((c >> 16) & 32'h7ff) + 1)),
                ref_div_o)
            `CHK("refsel", 2'(i % 3), reference_select_o)
            `CHK("filt", 2'(i % 4), loop_filter_o)
            `CHK("low_power_loop", 1'((c >> 2) & 1), low_power_loop_o)
        end
        // on demand, lock time-out 8 ms, gate until lock
        wr(FPCS_CTRL_B_OFS, 32'h400);
        wr(FPCS_IRQ_MASK_OFS, 32'hf);
        wr(FPCS_CTRL_A_OFS, 32'h82);
        cyc(20);
        `CHK("no_req_run", 1'b0, pll_run_o)
        @(posedge clk_sys_i);
        clk_request_i <= 1'b1;
        poll(2, 1'b1, 10); `CHK("en_stat", 1'b1, rd_q[2])
        `CHK("presc_off", 1'b0, rd_q[3])
        cyc(100);
        rd(FPCS_STATE_OFS); `CHK("gated", 1'b0, rd_q[1])
        rd(FPCS_IRQ_STAT_OFS); `CHK("to_early", 1'b0, rd_q[3])
        cyc(100);
        rd(FPCS_IRQ_STAT_OFS); `CHK("to_set", 1'b1, rd_q[3])
        `CHK("irq_on", 1'b1, irq_o)
        wr(FPCS_IRQ_STAT_OFS, 32'hf);
        cyc(3);
        `CHK("irq_clr", 1'b0, irq_o)
        lock_en <= 1'b1;
        poll(0, 1'b1, 20); `CHK("lock", 1'b1, rd_q[0])
        poll(1, 1'b1, 20); `CHK("clk_on", 1'b1, rd_q[1])
        rd(FPCS_IRQ_STAT_OFS); `CHK("ev", 3'b101, rd_q[2:0])
        lock_en <= 1'b0;
        poll(1, 1'b0, 20); `CHK("clk_off", 1'b0, rd_q[1])
        wr(FPCS_CTRL_B_OFS, 32'h1000);
        poll(1, 1'b1, 20); `CHK("bypass", 1'b1, rd_q[1])
        `CHK("bp_nolock", 1'b0, rd_q[0])
        wr(FPCS_IRQ_MASK_OFS, 32'h0);
        cyc(3);
        `CHK("masked", 1'b0, irq_o)
        wr(FPCS_IRQ_MASK_OFS, 32'hf);
        cyc(3);
        `CHK("unmasked", 1'b1, irq_o)
        // fast wake-up on main crystal: clock runs before any lock
        wr(FPCS_CTRL_A_OFS, 32'h80);
        poll(2, 1'b0, 20); `CHK("dis_stat", 1'b0, rd_q[2])
        wr(FPCS_CTRL_B_OFS, 32'h18);
        // always-on mode this time, enable alone starts the loop
        wr(FPCS_CTRL_A_OFS, 32'h02);
        poll(1, 1'b1, 80); `CHK("fast_wu", 1'b1, rd_q[1])
        `CHK("clk_pin", 1'b1, output_clock_running_o)
        `CHK("run_pin", 1'b1, pll_run_o)
        `CHK("presc_on", 1'b1, rd_q[3])
        `CHK("presc_pin", 1'b1, prescaler_en_o)
        summarize();
    end
endmodule : tb

`default_nettype wire
